// >>> logic/sfc_pkg.sv
package sfc_pkg;
	// Instruction codes
	localparam logic [7:0] OP_WREN      = 8'h06;
	localparam logic [7:0] OP_WRDI      = 8'h04;
	localparam logic [7:0] OP_RDSR1     = 8'h05;
	localparam logic [7:0] OP_RDSR3     = 8'h15;
	localparam logic [7:0] OP_WRSR1     = 8'h01;
	localparam logic [7:0] OP_WRSR3     = 8'h11;
	localparam logic [7:0] OP_PP        = 8'h02;
	localparam logic [7:0] OP_PP4       = 8'h12;
	localparam logic [7:0] OP_SE        = 8'h20;
	localparam logic [7:0] OP_SE4       = 8'h21;
	localparam logic [7:0] OP_BE        = 8'hD8;
	localparam logic [7:0] OP_BE4       = 8'hDC;
	localparam logic [7:0] OP_CE        = 8'hC7;
	localparam logic [7:0] OP_EN4B      = 8'hB7;
	localparam logic [7:0] OP_EX4B      = 8'hE9;
	localparam logic [7:0] OP_RSTEN     = 8'h66;
	localparam logic [7:0] OP_RST       = 8'h99;
	localparam logic [7:0] OP_PD        = 8'hB9;
	localparam logic [7:0] OP_RELPD     = 8'hAB;
	localparam logic [7:0] OP_UNLOCK    = 8'h39;
	localparam logic [7:0] OP_UNLOCK4   = 8'h3A;
	localparam logic [7:0] OP_SUSPEND   = 8'h75;
	localparam logic [7:0] OP_WREAR     = 8'hC5;
	// Status register 1 fields
	localparam int SR1_BUSY_POS  = 0;
	localparam int SR1_WEL_POS   = 1;
	localparam int SR1_BP_LSB    = 2;
	localparam int SR1_TB_POS    = 6;
	localparam int SR1_SRP_POS   = 7;
	// Status register 3 fields (bits of byte 3)
	localparam int SR3_ADS_POS   = 0;
	localparam int SR3_ADP_POS   = 1;
	localparam int SR3_WPS_POS   = 2;
	localparam int SR3_CMP_POS   = 3;
	localparam int SR3_SRL_POS   = 4;
	// Lock map
	localparam int NUM_LOCKS     = 542;
	localparam int NUM_MID_BLK   = 510;
	localparam int NUM_EDGE_SEC  = 16;
	localparam int NUM_BLOCKS    = 512;
	// Timing
	localparam int CLK_MHZ         = 25;
	localparam int SOFT_RST_NS     = 30000;
	localparam int MIN_CLEAR_NS    = 1000;
	localparam int SOFT_RST_CYC    = (SOFT_RST_NS * CLK_MHZ + 999) / 1000;
	localparam int MIN_CLEAR_CYC   = (MIN_CLEAR_NS * CLK_MHZ + 999) / 1000;
	localparam int PUW_CYC_DEF     = 250000;
	localparam int OP_CYC_DEF      = 2500;
	// Interrupt event bits
	localparam int EV_DONE         = 0;
	localparam int EV_REJECT       = 1;
	localparam int EV_RESET        = 2;
	localparam int EV_W            = 3;
	localparam logic [2:0] EV_ZERO = 3'h0;
	localparam logic [7:0] REG_EV_STAT = 8'h00;
	localparam logic [7:0] REG_EV_MASK = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_NV      = 8'h0C;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_DATA = 3'b010,
		ST_READ = 3'b011,
		ST_SKIP = 3'b100
	} sfc_state_type;
endpackage

// >>> logic/sfc_core.sv
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module sfc_core #(
	parameter int PUW_CYC = sfc_pkg::PUW_CYC_DEF,
	parameter int OP_CYC  = sfc_pkg::OP_CYC_DEF
) (
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       spi_cs_n_in,
	input  wire logic       spi_clk_in,
	input  wire logic       spi_di_in,
	input  wire logic       write_protect_n_in,
	input  wire logic       clear_n_in,
	input  wire logic       powerup_addr_width_sel_in,
	output logic            spi_do_out,
	output logic            spi_do_oe_out,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic [31:0]     reg_rdata_out,
	output logic            irq_out,
	output logic            erase_start_out,
	output logic            program_start_out,
	output logic [31:0]     op_addr_out
);
	logic [1:0] cs_s_q, ck_s_q, di_s_q, wp_s_q, clr_s_q;
	logic       ck_last_q;
	always_ff @(posedge clk_in) begin
		cs_s_q  <= {cs_s_q[0], spi_cs_n_in};
		ck_s_q  <= {ck_s_q[0], spi_clk_in};
		di_s_q  <= {di_s_q[0], spi_di_in};
		wp_s_q  <= {wp_s_q[0], write_protect_n_in};
		clr_s_q <= {clr_s_q[0], clear_n_in};
		ck_last_q <= ck_s_q[1];
	end
	wire logic cs_n = cs_s_q[1];
	wire logic rise = ck_s_q[1] & ~ck_last_q & ~cs_n;
	wire logic fall = ~ck_s_q[1] & ck_last_q & ~cs_n;
	logic [7:0] clr_cnt_q;
	logic       hw_clear;
	always_ff @(posedge clk_in) begin
		if (rst_in || clr_s_q[1])
			clr_cnt_q <= 8'h00;
		else if (clr_cnt_q < 8'(sfc_pkg::MIN_CLEAR_CYC))
			clr_cnt_q <= clr_cnt_q + 8'h01;
	end
	assign hw_clear = (clr_cnt_q == 8'(sfc_pkg::MIN_CLEAR_CYC));
	// Serial shifter, MSB first
	logic [7:0] sh_q;
	logic [2:0] bit_q;
	logic       byte_done;
	always_ff @(posedge clk_in) begin
		if (rst_in || cs_n) begin
			bit_q <= 3'h0;
			sh_q  <= 8'h00;
		end else if (rise) begin
			sh_q  <= {sh_q[6:0], di_s_q[1]};
			bit_q <= bit_q + 3'h1;
		end
	end
	assign byte_done = rise && (bit_q == 3'h7);
	wire logic [7:0] rx_byte = {sh_q[6:0], di_s_q[1]};
	logic cs_last_q;
	always_ff @(posedge clk_in) cs_last_q <= cs_n;
	wire logic cs_rise = cs_n & ~cs_last_q;
	// Status state
	logic       wel_q, ads_q, adp_q, wps_q, cmp_q, tb_q, srp_q, srl_q;
	logic [3:0] bp_q;
	logic [7:0] ext_addr_q;
	logic       busy_q, pd_q, rsten_q, soft_rst_q, init_q;
	logic [31:0] busy_cnt_q, puw_cnt_q;
	logic [sfc_pkg::NUM_LOCKS-1:0] lock_q;
	sfc_pkg::sfc_state_type st_q;
	logic [7:0] op_q;
	logic [2:0] addr_bytes_q, addr_cnt_q;
	logic [31:0] addr_q;
	logic [7:0] tx_q;
	wire logic reset_any = rst_in | hw_clear;
	always_ff @(posedge clk_in) begin
		if (reset_any)
			puw_cnt_q <= 32'(PUW_CYC);
		else if (puw_cnt_q != 32'h0)
			puw_cnt_q <= puw_cnt_q - 32'h1;
	end
	wire logic lockout = (puw_cnt_q != 32'h0);
	function automatic logic is_write_op(input logic [7:0] op);
		case (op)
			sfc_pkg::OP_WREN, sfc_pkg::OP_PP, sfc_pkg::OP_PP4, sfc_pkg::OP_SE, sfc_pkg::OP_SE4,
			sfc_pkg::OP_BE, sfc_pkg::OP_BE4, sfc_pkg::OP_CE, sfc_pkg::OP_WRSR1, sfc_pkg::OP_WRSR3:
				is_write_op = 1'b1;
			default:
				is_write_op = 1'b0;
		endcase
	endfunction
	function automatic logic is_4b_op(input logic [7:0] op);
		is_4b_op = (op == sfc_pkg::OP_PP4) || (op == sfc_pkg::OP_SE4) ||
			(op == sfc_pkg::OP_BE4) || (op == sfc_pkg::OP_UNLOCK4);
	endfunction
	function automatic logic needs_addr(input logic [7:0] op);
		case (op)
			sfc_pkg::OP_PP, sfc_pkg::OP_PP4, sfc_pkg::OP_SE, sfc_pkg::OP_SE4, sfc_pkg::OP_BE,
			sfc_pkg::OP_BE4, sfc_pkg::OP_UNLOCK, sfc_pkg::OP_UNLOCK4:
				needs_addr = 1'b1;
			default:
				needs_addr = 1'b0;
		endcase
	endfunction
	function automatic logic [9:0] lock_idx(input logic [31:0] a);
		logic [8:0] blk;
		blk = a[24:16];
		if (blk == 9'h000)
			lock_idx = {6'h00, a[15:12]};
		else if (blk == 9'h1FF)
			lock_idx = 10'(sfc_pkg::NUM_EDGE_SEC) + {6'h00, a[15:12]};
		else
			lock_idx = 10'(2 * sfc_pkg::NUM_EDGE_SEC) + {1'b0, blk} - 10'h001;
	endfunction
	function automatic logic bp_protected(input logic [31:0] a, input logic [3:0] bp,
		input logic tb, input logic cmp);
		logic [8:0] blk;
		logic [9:0] n;
		logic       hit;
		blk = a[24:16];
		n   = (bp == 4'h0) ? 10'h000 : ((bp >= 4'hA) ? 10'h200 : 10'(1 << (bp - 4'h1)));
		if (tb)
			hit = ({1'b0, blk} < n);
		else
			hit = ({1'b0, blk} >= 10'h200 - n);
		bp_protected = hit ^ cmp;
	endfunction
	wire logic addr_done = byte_done && (st_q == sfc_pkg::ST_ADDR) && (addr_cnt_q == addr_bytes_q - 3'h1);
	wire logic [31:0] full_addr = {addr_q[23:0], rx_byte};
	// extended register used only in 3-byte form
	wire logic [31:0] eff_addr = (addr_bytes_q == 3'h4) ? full_addr : {ext_addr_q, full_addr[23:0]};
	wire logic prot_hit = wps_q ? lock_q[lock_idx(eff_addr)] : bp_protected(eff_addr, bp_q, tb_q, cmp_q);
	wire logic accept_cmd = byte_done && (st_q == sfc_pkg::ST_IDLE) && !soft_rst_q;
	// busy admits only status read and suspend; power-down admits only release
	wire logic allowed = pd_q ? (rx_byte == sfc_pkg::OP_RELPD) :
		busy_q ? (rx_byte == sfc_pkg::OP_RDSR1 || rx_byte == sfc_pkg::OP_RDSR3 || rx_byte == sfc_pkg::OP_SUSPEND) :
		!(lockout && is_write_op(rx_byte));
	wire logic sr_writable = wel_q && !srl_q && !(srp_q && !wp_s_q[1]);
	logic ev_done, ev_reject;
	// Command decoder
	always_ff @(posedge clk_in) begin
		if (reset_any || soft_rst_q) begin
			st_q <= sfc_pkg::ST_IDLE;
			op_q <= 8'h00;
			addr_cnt_q <= 3'h0;
			addr_bytes_q <= 3'h3;
			addr_q <= 32'h0;
		end else if (cs_n) begin
			st_q <= sfc_pkg::ST_IDLE;
		end else if (accept_cmd) begin
			op_q <= rx_byte;
			addr_cnt_q <= 3'h0;
			addr_bytes_q <= (is_4b_op(rx_byte) || ads_q) ? 3'h4 : 3'h3;
			if (!allowed)
				st_q <= sfc_pkg::ST_SKIP;
			else if (needs_addr(rx_byte))
				st_q <= sfc_pkg::ST_ADDR;
			else if (rx_byte == sfc_pkg::OP_RDSR1 || rx_byte == sfc_pkg::OP_RDSR3)
				st_q <= sfc_pkg::ST_READ;
			else
				st_q <= sfc_pkg::ST_DATA;
		end else if (byte_done && st_q == sfc_pkg::ST_ADDR) begin
			addr_q <= full_addr;
			addr_cnt_q <= addr_cnt_q + 3'h1;
			if (addr_done)
				st_q <= sfc_pkg::ST_SKIP;
		end else if (byte_done && st_q == sfc_pkg::ST_DATA) begin
			addr_q <= {addr_q[23:0], rx_byte};
		end
	end
	// Output status byte on falling edges
	wire logic [7:0] sr1 = {srp_q, tb_q, bp_q, wel_q, busy_q};
	wire logic [7:0] sr3 = {3'h0, srl_q, cmp_q, wps_q, adp_q, ads_q};
	always_ff @(posedge clk_in) begin
		if (reset_any || cs_n) begin
			tx_q <= 8'h00;
			spi_do_oe_out <= 1'b0;
		end else if (accept_cmd && allowed && rx_byte == sfc_pkg::OP_RDSR1) begin
			tx_q <= sr1;
			spi_do_oe_out <= 1'b1;
		end else if (accept_cmd && allowed && rx_byte == sfc_pkg::OP_RDSR3) begin
			tx_q <= sr3;
			spi_do_oe_out <= 1'b1;
		end else if (fall && st_q == sfc_pkg::ST_READ && bit_q != 3'h0) begin
			tx_q <= {tx_q[6:0], 1'b0};
		end else if (fall && st_q == sfc_pkg::ST_READ) begin
			tx_q <= (op_q == sfc_pkg::OP_RDSR1) ? sr1 : sr3;
		end
	end
	assign spi_do_out = tx_q[7];
	// Command completion at chip select rise, byte boundary only; a cut frame acts on nothing
	wire logic fin = cs_rise && bit_q == 3'h0 && (st_q == sfc_pkg::ST_DATA || st_q == sfc_pkg::ST_READ ||
		st_q == sfc_pkg::ST_SKIP && addr_cnt_q == addr_bytes_q);
	wire logic is_erase = (op_q == sfc_pkg::OP_SE || op_q == sfc_pkg::OP_SE4 || op_q == sfc_pkg::OP_BE ||
		op_q == sfc_pkg::OP_BE4);
	wire logic is_prog = (op_q == sfc_pkg::OP_PP || op_q == sfc_pkg::OP_PP4);
	wire logic [31:0] op_addr = (addr_bytes_q == 3'h4) ? addr_q : {ext_addr_q, addr_q[23:0]};
	logic prot_q;
	always_ff @(posedge clk_in) begin
		if (reset_any)
			prot_q <= 1'b0;
		else if (addr_done)
			prot_q <= prot_hit;
	end
	wire logic arr_go = fin && (is_erase || is_prog) && wel_q && !prot_q;
	wire logic ce_go = fin && op_q == sfc_pkg::OP_CE && wel_q &&
		(wps_q ? !(|lock_q) : (bp_q == 4'h0 && !cmp_q));
	wire logic sr_go = fin && (op_q == sfc_pkg::OP_WRSR1 || op_q == sfc_pkg::OP_WRSR3) && sr_writable;
	always_ff @(posedge clk_in) begin
		if (reset_any) begin
			erase_start_out <= 1'b0;
			program_start_out <= 1'b0;
			op_addr_out <= 32'h0;
		end else begin
			erase_start_out <= (arr_go && is_erase) || ce_go;
			program_start_out <= arr_go && is_prog;
			if (arr_go)
				op_addr_out <= op_addr;
		end
	end
	// busy timer, also soft reset period
	always_ff @(posedge clk_in) begin
		if (reset_any) begin
			busy_q <= 1'b0;
			busy_cnt_q <= 32'h0;
			soft_rst_q <= 1'b0;
		end else if (fin && op_q == sfc_pkg::OP_RST && rsten_q) begin
			busy_q <= 1'b1;
			soft_rst_q <= 1'b1;
			busy_cnt_q <= 32'(sfc_pkg::SOFT_RST_CYC);
		end else if (arr_go || ce_go || sr_go) begin
			busy_q <= 1'b1;
			busy_cnt_q <= 32'(OP_CYC);
		end else if (busy_cnt_q > 32'h1) begin
			busy_cnt_q <= busy_cnt_q - 32'h1;
		end else if (busy_q) begin
			busy_q <= 1'b0;
			soft_rst_q <= 1'b0;
			busy_cnt_q <= 32'h0;
		end
	end
	wire logic op_end = busy_q && busy_cnt_q <= 32'h1 && !soft_rst_q;
	wire logic soft_end = busy_q && busy_cnt_q <= 32'h1 && soft_rst_q;
	wire logic full_init = reset_any || soft_end;
	// enable-reset must be the immediately preceding command
	always_ff @(posedge clk_in) begin
		if (full_init)
			rsten_q <= 1'b0;
		else if (fin)
			rsten_q <= (op_q == sfc_pkg::OP_RSTEN);
	end
	always_ff @(posedge clk_in) begin
		if (full_init || op_end)
			wel_q <= 1'b0;
		else if (fin && op_q == sfc_pkg::OP_WREN)
			wel_q <= 1'b1;
		else if (fin && op_q == sfc_pkg::OP_WRDI)
			wel_q <= 1'b0;
	end
	always_ff @(posedge clk_in) begin
		if (full_init)
			ads_q <= adp_q;
		else if (init_q)
			ads_q <= powerup_addr_width_sel_in;
		else if (fin && op_q == sfc_pkg::OP_EN4B)
			ads_q <= 1'b1;
		else if (fin && op_q == sfc_pkg::OP_EX4B)
			ads_q <= 1'b0;
	end
	// nonvolatile select captured after reset release; status writes
	always_ff @(posedge clk_in) begin
		init_q <= rst_in;
		if (rst_in) begin
			adp_q <= 1'b0;
			wps_q <= 1'b0;
			cmp_q <= 1'b0;
			tb_q  <= 1'b0;
			srp_q <= 1'b0;
			srl_q <= 1'b0;
			bp_q  <= 4'h0;
		end else if (init_q) begin
			adp_q <= powerup_addr_width_sel_in;
		end else if (sr_go && op_q == sfc_pkg::OP_WRSR1) begin
			bp_q  <= addr_q[5:2];
			tb_q  <= addr_q[sfc_pkg::SR1_TB_POS];
			srp_q <= addr_q[sfc_pkg::SR1_SRP_POS];
		end else if (sr_go) begin
			adp_q <= addr_q[sfc_pkg::SR3_ADP_POS];
			wps_q <= addr_q[sfc_pkg::SR3_WPS_POS];
			cmp_q <= addr_q[sfc_pkg::SR3_CMP_POS];
			srl_q <= addr_q[sfc_pkg::SR3_SRL_POS];
		end
	end
	always_ff @(posedge clk_in) begin
		if (full_init)
			pd_q <= 1'b0;
		else if (fin && op_q == sfc_pkg::OP_PD)
			pd_q <= 1'b1;
		else if (fin && op_q == sfc_pkg::OP_RELPD)
			pd_q <= 1'b0;
	end
	// locks set at reset, unlocked by instruction
	always_ff @(posedge clk_in) begin
		if (full_init)
			lock_q <= '1;
		else if (fin && (op_q == sfc_pkg::OP_UNLOCK || op_q == sfc_pkg::OP_UNLOCK4))
			lock_q[lock_idx(op_addr)] <= 1'b0;
	end
	// Extended address register byte
	always_ff @(posedge clk_in) begin
		if (full_init)
			ext_addr_q <= 8'h00;
		else if (fin && op_q == sfc_pkg::OP_WREAR && wel_q)
			ext_addr_q <= addr_q[7:0];
	end
	assign ev_done = op_end;
	assign ev_reject = accept_cmd && !allowed;
	// Interrupt status and mask
	logic [2:0] ev_stat_q, ev_mask_q;
	wire logic [2:0] ev_set = {soft_end | hw_clear, ev_reject, ev_done};
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ev_stat_q <= sfc_pkg::EV_ZERO;
			ev_mask_q <= sfc_pkg::EV_ZERO;
		end else begin
			if (reg_wr_in && reg_addr_in == sfc_pkg::REG_EV_STAT)
				ev_stat_q <= (ev_stat_q & ~reg_wdata_in[2:0]) | ev_set;
			else
				ev_stat_q <= ev_stat_q | ev_set;
			if (reg_wr_in && reg_addr_in == sfc_pkg::REG_EV_MASK)
				ev_mask_q <= reg_wdata_in[2:0];
		end
	end
	assign irq_out = |(ev_stat_q & ev_mask_q);
	always_ff @(posedge clk_in) begin
		if (rst_in)
			reg_rdata_out <= 32'h0;
		else if (reg_rd_in) begin
			case (reg_addr_in)
				sfc_pkg::REG_EV_STAT: reg_rdata_out <= {29'h0, ev_stat_q};
				sfc_pkg::REG_EV_MASK: reg_rdata_out <= {29'h0, ev_mask_q};
				sfc_pkg::REG_STATUS:  reg_rdata_out <= {16'h0, sr3, sr1};
				sfc_pkg::REG_NV:      reg_rdata_out <= {22'h0, pd_q, lockout, ext_addr_q};
				default:              reg_rdata_out <= 32'h0;
			endcase
		end else
			reg_rdata_out <= 32'h0;
	end
endmodule
`default_nettype wire

// >>> testbench/sfc_host.sv
`timescale 1ns/10ps
`default_nettype none
module sfc_host (
	input  wire logic spi_do_in,
	input  wire logic spi_do_oe_in,
	output logic      spi_cs_n_out,
	output logic      spi_clk_out,
	output logic      spi_di_out
);
	initial begin
		spi_cs_n_out = 1'b1;
		spi_clk_out = 1'b0;
		spi_di_out = 1'b0;
	end
	task automatic frame(input logic [7:0] q[$], input int nrd, output logic [7:0] rx);
		#13 spi_cs_n_out = 1'b0;
		for (int i = 0; i < q.size() + nrd; i++) begin
			for (int b = 7; b >= 0; b--) begin
				spi_di_out = (i < q.size()) ? q[i][b] : ~spi_di_out;
				#160 spi_clk_out = 1'b1;
				rx = {rx[6:0], spi_do_oe_in ? spi_do_in : 1'bx};
				#160 spi_clk_out = 1'b0;
			end
		end
		#160 spi_cs_n_out = 1'b1;
		spi_di_out = ~spi_di_out;
		#400;
	endtask
endmodule
`default_nettype wire

// >>> testbench/sfc_core_props.sv
`timescale 1ns/10ps
`default_nettype none
module sfc_core_props #(
	parameter int PUW_CYC = sfc_pkg::PUW_CYC_DEF
) (
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        spi_cs_n_in,
	input wire logic        spi_clk_in,
	input wire logic        clear_n_in,
	input wire logic        reg_wr_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic        spi_do_out,
	input wire logic        spi_do_oe_out,
	input wire logic        irq_out,
	input wire logic        erase_start_out,
	input wire logic        program_start_out
);
	logic [31:0] up_q;
	logic [5:0]  clr_q;
	always_ff @(posedge clk_in) begin
		if (rst_in)
			up_q <= 32'h0;
		else if (up_q < PUW_CYC)
			up_q <= up_q + 32'h1;
	end
	always_ff @(posedge clk_in) begin
		if (clear_n_in)
			clr_q <= 6'h0;
		else if (clr_q != 6'h3F)
			clr_q <= clr_q + 6'h1;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_start;
		erase_start_out || program_start_out;
	endsequence
	sequence s_quiet;
		!(erase_start_out || program_start_out) [*8];
	endsequence
	AST_BUSY_GAP: assert property (s_start |=> s_quiet)
		else $error("array op started while busy");
	AST_LOCKOUT: assert property (s_start |-> up_q >= PUW_CYC)
		else $error("array op during power-up lockout");
	AST_START_CS: assert property (s_start |-> spi_cs_n_in)
		else $error("array op started inside a frame");
	AST_RST_QUIET: assert property (disable iff (1'b0) rst_in |=> !(erase_start_out || program_start_out) && !irq_out)
		else $error("output active after reset");
	AST_CLEAR_QUIET: assert property (clr_q > 6'h20 |-> !spi_do_oe_out && !erase_start_out && !program_start_out)
		else $error("activity while clear pin held");
	AST_OE_CS: assert property (spi_cs_n_in [*6] |-> !spi_do_oe_out)
		else $error("data out driven while deselected");
	AST_DO_FALL: assert property ($changed(spi_do_out) && spi_do_oe_out && $past(spi_do_oe_out) |-> !$past(spi_clk_in, 2))
		else $error("data out moved outside low clock phase");
	AST_IRQ_MASK: assert property (reg_wr_in && reg_addr_in == sfc_pkg::REG_EV_MASK
		&& reg_wdata_in[2:0] == sfc_pkg::EV_ZERO |-> ##2 !irq_out)
		else $error("interrupt high with all events masked");
endmodule
bind sfc_core sfc_core_props #(.PUW_CYC(PUW_CYC)) props (.clk_in(clk_in), .rst_in(rst_in),
	.spi_cs_n_in(spi_cs_n_in), .spi_clk_in(spi_clk_in), .clear_n_in(clear_n_in), .reg_wr_in(reg_wr_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .spi_do_out(spi_do_out),
	.spi_do_oe_out(spi_do_oe_out), .irq_out(irq_out), .erase_start_out(erase_start_out),
	.program_start_out(program_start_out));
`default_nettype wire

// >>> testbench/sfc_core_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module sfc_core_test;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wp_n = 1'b1;
	logic        clr_n = 1'b1;
	logic        powerup_addr_width_sel = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] seed = 32'hC9D7F9DF;
	logic [31:0] rdata, op_addr, r, a;
	logic        irq, prog, ers, cs_n, sck, di, dout, doe;
	logic [7:0]  rx, ext;
	logic [7:0]  ops [4] = '{sfc_pkg::OP_PP, sfc_pkg::OP_PP4, sfc_pkg::OP_PP, sfc_pkg::OP_SE4};
	int          n_errors = 0;
	int          checked = 0;
	int          n_starts = 0;
	int          ns = 0;
	always #20 clk = ~clk;
	always @(posedge clk) if (prog === 1'b1 || ers === 1'b1) n_starts <= n_starts + 1;
	sfc_core #(.PUW_CYC(400), .OP_CYC(200)) dut (.clk_in(clk), .rst_in(rst), .spi_cs_n_in(cs_n), .spi_clk_in(sck),
		.spi_di_in(di), .write_protect_n_in(wp_n), .clear_n_in(clr_n), .powerup_addr_width_sel_in(powerup_addr_width_sel),
		.spi_do_out(dout), .spi_do_oe_out(doe), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq), .erase_start_out(ers),
		.program_start_out(prog), .op_addr_out(op_addr));
	sfc_host host (.spi_do_in(dout), .spi_do_oe_in(doe), .spi_cs_n_out(cs_n), .spi_clk_out(sck), .spi_di_out(di));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [31:0] exp_addr(input logic [31:0] ad, input bit four);
		return four ? ad : {ext, ad[23:0]};
	endfunction
	task automatic wreg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] ad, output logic [31:0] d);
		@(posedge clk);
		addr <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic stat();
		rreg(sfc_pkg::REG_STATUS, r);
	endtask
	task automatic settle();
		repeat (220) @(posedge clk);
	endtask
	task automatic cmd(input logic [7:0] q[$]);
		host.frame(q, 0, rx);
	endtask
	task automatic wen();
		cmd('{sfc_pkg::OP_WREN});
	endtask
	task automatic cmd_a(input logic [7:0] op, input logic [31:0] ad, input bit four);
		if (four)
			cmd('{op, ad[31:24], ad[23:16], ad[15:8], ad[7:0]});
		else
			cmd('{op, ad[23:16], ad[15:8], ad[7:0]});
	endtask
	// Write-enabled array op; ok says whether a start pulse must follow
	task automatic op(input logic [7:0] o, input logic [31:0] ad, input bit ok);
		wen();
		cmd_a(o, ad, 1'b1);
		settle();
		if (ok) begin
			ns++;
			`CHK(op_addr, ad)
		end
		`CHK(n_starts, ns)
	endtask
	task automatic results();
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#1ms;
		n_errors++;
		results();
	end
	initial begin
		a = rnd();
		powerup_addr_width_sel <= a[0];
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		wen();
		stat();
		`CHK(r[1], 1'b0)
		`CHK(r[8], powerup_addr_width_sel)
		rreg(sfc_pkg::REG_EV_STAT, r);
		`CHK(r[sfc_pkg::EV_REJECT], 1'b1)
		wreg(sfc_pkg::REG_EV_MASK, 32'h2);
		@(posedge clk);
		#1 `CHK(irq, 1'b1)
		wreg(sfc_pkg::REG_EV_STAT, 32'h7);
		@(posedge clk);
		#1 `CHK(irq, 1'b0)
		wreg(sfc_pkg::REG_EV_MASK, 32'h0);
		rreg(8'hF0, r);
		`CHK(r, 32'h0)
		repeat (400) @(posedge clk);
		cmd_a(sfc_pkg::OP_PP4, a, 1'b1);
		`CHK(n_starts, ns)
		ext = 8'(rnd()) | 8'h01;
		wen();
		cmd('{sfc_pkg::OP_WREAR, ext});
		rreg(sfc_pkg::REG_NV, r);
		`CHK(r[7:0], ext)
		`CHK(r[9:8], 2'b00)
		cmd('{sfc_pkg::OP_WRDI});
		stat();
		`CHK(r[1], 1'b0)
		for (int m = 0; m < 4; m++) begin
			if (m == 0)
				cmd('{sfc_pkg::OP_EX4B});
			if (m == 2)
				cmd('{sfc_pkg::OP_EN4B});
			stat();
			`CHK(r[8], m >= 2)
			a = rnd() & 32'h01FFF000;
			wen();
			cmd_a(ops[m], a, m != 0);
			stat();
			`CHK(r[0], 1'b1)
			wen();
			settle();
			ns++;
			`CHK(n_starts, ns)
			`CHK(op_addr, exp_addr(a, m != 0))
			stat();
			`CHK(r[1:0], 2'b00)
		end
		cmd('{sfc_pkg::OP_PD});
		wen();
		cmd('{sfc_pkg::OP_RELPD});
		stat();
		`CHK(r[1], 1'b0)
		wen();
		host.frame('{sfc_pkg::OP_RDSR1}, 1, rx);
		`CHK(rx, 8'h02)
		cmd('{sfc_pkg::OP_WRSR3, {5'h00, 1'b1, powerup_addr_width_sel, 1'b0}});
		settle();
		stat();
		`CHK(r[15:8], {5'h00, 1'b1, powerup_addr_width_sel, 1'b1})
		host.frame('{sfc_pkg::OP_RDSR3}, 1, rx);
		`CHK(rx, {5'h00, 1'b1, powerup_addr_width_sel, 1'b1})
		a = (rnd() & 32'h00FEF000) | 32'h00010000;
		op(sfc_pkg::OP_SE4, a, 1'b0);
		op(sfc_pkg::OP_UNLOCK4, a, 1'b0);
		op(sfc_pkg::OP_SE4, a, 1'b1);
		op(sfc_pkg::OP_UNLOCK4, 32'h0, 1'b0);
		op(sfc_pkg::OP_SE4, 32'h1000, 1'b0);
		cmd('{sfc_pkg::OP_RSTEN});
		wen();
		cmd('{sfc_pkg::OP_RST});
		op(sfc_pkg::OP_SE4, a, 1'b1);
		cmd('{sfc_pkg::OP_RSTEN});
		cmd('{sfc_pkg::OP_RST});
		stat();
		`CHK(r[0], 1'b1)
		repeat (800) @(posedge clk);
		stat();
		`CHK(r[8], powerup_addr_width_sel)
		op(sfc_pkg::OP_SE4, a, 1'b0);
		op(sfc_pkg::OP_CE, 32'h0, 1'b0);
		wen();
		cmd('{sfc_pkg::OP_WRSR3, {5'h00, 1'b0, powerup_addr_width_sel, 1'b0}});
		settle();
		wen();
		cmd('{sfc_pkg::OP_WRSR1, 8'h04});
		settle();
		stat();
		`CHK(r[7:0], 8'h04)
		op(sfc_pkg::OP_SE4, 32'h01FF0000 | (rnd() & 32'hF000), 1'b0);
		op(sfc_pkg::OP_SE4, 32'h01FE0000, 1'b1);
		wen();
		cmd('{sfc_pkg::OP_WRSR1, 8'h84});
		settle();
		wp_n <= 1'b0;
		wen();
		cmd('{sfc_pkg::OP_WRSR1, 8'h00});
		settle();
		stat();
		`CHK(r[7:2], 6'h21)
		wp_n <= 1'b1;
		wen();
		cmd('{sfc_pkg::OP_WRSR1, 8'h00});
		settle();
		stat();
		`CHK(r[7:0], 8'h00)
		wen();
		cmd('{sfc_pkg::OP_CE});
		settle();
		ns++;
		`CHK(n_starts, ns)
		wen();
		clr_n <= 1'b0;
		repeat (10) @(posedge clk);
		clr_n <= 1'b1;
		repeat (4) @(posedge clk);
		stat();
		`CHK(r[1], 1'b1)
		clr_n <= 1'b0;
		repeat (40) @(posedge clk);
		clr_n <= 1'b1;
		repeat (4) @(posedge clk);
		stat();
		`CHK(r[1:0], 2'b00)
		results();
	end
endmodule
`default_nettype wire
